// ---- hw/erw_pkg.sv ----
// Shared types and constants for the external bus ready and wait-state sequencer
package erw_pkg;
	// Bus data width
	localparam int DATA_W = 16;
	// Width of the access length field and of the phase timer
	localparam int PHASE_W = 6;
	// Access phase legal range, in bus clock periods
	localparam logic [5:0] ACC_MIN = 6'h01;
	localparam logic [5:0] ACC_MAX = 6'h20;
	// Command delay and hold phase upper limit, in bus clock periods
	localparam logic [1:0] CMD_MAX = 2'h3;
	localparam logic [1:0] HOLD_MAX = 2'h3;
	// Idle level of the active-low command strobes
	localparam logic STROBE_IDLE = 1'h1;
	// Idle level of the active-low data output enable
	localparam logic OE_N_IDLE = 1'h1;
	// Reset value of the crossing toggles
	localparam logic TGL_RST = 1'h0;
	// Reset value of the data registers
	localparam logic [15:0] DATA_RST = 16'h0000;

	// One bus cycle request with its programmed phases
	typedef struct packed {
		logic write;             // 1 = write cycle, 0 = read cycle
		logic ready_ctrl;        // Cycle is ended by the ready input
		logic ready_async;       // Ready passes the extra sync stage
		logic ready_pol;         // Active level of the ready input
		logic [1:0] cmd_delay;   // Command delay phase, 0..3
		logic [5:0] access_len;  // Access phase, 1..32
		logic [1:0] hold_len;    // Hold phase, 0..3
		logic [15:0] wdata;      // Write data
	} erw_req_t;

	// Active-low command strobes on the bus
	typedef struct packed {
		logic rd_n;
		logic wr_n;
	} erw_strobe_t;

	// Bus-side cycle sequencer states
	typedef enum logic [2:0] {
		ERW_IDLE,
		ERW_DELAY,
		ERW_ACCESS,
		ERW_RWAIT,
		ERW_HOLD
	} erw_state_t;
endpackage

// ---- hw/erw_sync2.sv ----
// Two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module erw_sync2 #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	// First stage, read only by the second stage
	logic [W-1:0] meta;
	// Second stage, safe for logic
	logic [W-1:0] stable;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_stable;

	// No reset: this also serves as the reset synchroniser itself
	always_comb begin
		next_meta = d_in;
		next_stable = meta;
	end

	// Register both stages
	always_ff @(posedge clk_in) begin
		meta <= next_meta;
		stable <= next_stable;
	end

	assign q_out = stable;
endmodule

// ---- hw/erw_phase_timer.sv ----
// Down counter that times one programmed bus phase
`timescale 1ns/1ps
module erw_phase_timer #(
	parameter int W = 6
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic load_in,
	input wire logic [W-1:0] value_in,
	output logic zero_out
);
	// Periods left in the current phase after this one
	logic [W-1:0] count;
	logic [W-1:0] next_count;

	initial begin
		if (W < 1) begin
			$error("erw_phase_timer: W must be at least 1");
		end
	end

	// Load wins over counting; hold at zero
	always_comb begin
		next_count = count;
		if (load_in) begin
			next_count = value_in;
		end else if (count != '0) begin
			next_count = count - W'(1);
		end
	end

	// Register the count
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	// Phase ends in the period where the count reads zero
	assign zero_out = (count == '0);
endmodule

// ---- hw/erw_ready_ctrl.sv ----
// Ready-controlled wait-state sequencer of the external bus controller
`timescale 1ns/1ps
module erw_ready_ctrl (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic clk_link_in,
	input wire logic req_valid_in,
	input wire erw_pkg::erw_req_t req_in,
	output logic req_ready_out,
	output logic done_out,
	output logic [erw_pkg::DATA_W-1:0] rdata_out,
	input wire logic ready_in,
	input wire logic [erw_pkg::DATA_W-1:0] data_in,
	output logic [erw_pkg::DATA_W-1:0] data_out,
	output logic data_oe_n_out,
	output erw_pkg::erw_strobe_t strobe_out,
	output logic bus_reference_clock_out
);
	// Phase length minus one, clipped to the timer width
	function automatic logic [erw_pkg::PHASE_W-1:0] len_m1(input logic [5:0] len);
		len_m1 = len - 6'h01;
	endfunction

	// Strobe pattern for a cycle in its command phase
	function automatic erw_pkg::erw_strobe_t strobe_on(input logic write);
		strobe_on.rd_n = write;
		strobe_on.wr_n = !write;
	endfunction

	// The timer must hold the longest access phase, less one
	initial begin
		if (erw_pkg::PHASE_W < 5) begin
			$error("erw_ready_ctrl: phase timer narrower than the access phase");
		end
	end

	// System domain state
	logic busy;                         // A request is out on the bus
	logic req_tgl;                      // Flips once per request
	logic done_seen;                    // Last done toggle taken
	logic done_pulse;                   // One-cycle completion
	logic [erw_pkg::DATA_W-1:0] rdata;  // Read data held for the user
	erw_pkg::erw_req_t req_hold;        // Request, stable while busy
	// Next values of the system side
	logic next_busy;
	logic next_req_tgl;
	logic next_done_seen;
	logic next_done_pulse;
	logic [erw_pkg::DATA_W-1:0] next_rdata;
	erw_pkg::erw_req_t next_req_hold;

	// Link domain state
	logic rst_link;                     // Reset as seen by the bus clock
	logic req_tgl_sync;                 // Request toggle after crossing
	logic done_tgl_sync;                // Done toggle back in system domain
	logic rdy_sync;                     // Raw ready after two flops
	logic req_seen;                     // Last request toggle taken
	logic done_tgl;                     // Flips once per finished cycle
	erw_pkg::erw_state_t state;
	erw_pkg::erw_strobe_t strobe;
	logic [erw_pkg::DATA_W-1:0] link_rdata;
	logic [erw_pkg::DATA_W-1:0] dout;
	logic oe_n;
	// Next values of the bus side
	erw_pkg::erw_state_t next_state;
	erw_pkg::erw_strobe_t next_strobe;
	logic [erw_pkg::DATA_W-1:0] next_link_rdata;
	logic [erw_pkg::DATA_W-1:0] next_dout;
	logic next_oe_n;
	logic next_req_seen;
	logic next_done_tgl;

	// Timer control and ready decoding
	logic tmr_load;
	logic [erw_pkg::PHASE_W-1:0] tmr_val;
	logic tmr_zero;
	logic rdy_pin_active;               // Synchronous sample of the pin
	logic rdy_async_active;             // Sample after the extra stage
	logic rdy_active;                   // Mode-selected sample
	logic end_cycle;                    // Strobe rises this period

	// Reset reaches the bus clock domain through two flops
	erw_sync2 #(.W(1)) u_rst_sync (
		.clk_in(clk_link_in),
		.d_in(rst_in),
		.q_out(rst_link)
	);

	// Request toggle crosses into the bus domain
	erw_sync2 #(.W(1)) u_req_sync (
		.clk_in(clk_link_in),
		.d_in(req_tgl),
		.q_out(req_tgl_sync)
	);

	// Done toggle crosses back into the system domain
	erw_sync2 #(.W(1)) u_done_sync (
		.clk_in(clk_sys_in),
		.d_in(done_tgl),
		.q_out(done_tgl_sync)
	);

	// Asynchronous ready passes two flops on the bus clock
	erw_sync2 #(.W(1)) u_rdy_sync (
		.clk_in(clk_link_in),
		.d_in(ready_in),
		.q_out(rdy_sync)
	);

	// Times the delay, access and hold phases
	erw_phase_timer #(.W(erw_pkg::PHASE_W)) u_timer (
		.clk_in(clk_link_in),
		.rst_in(rst_link),
		.load_in(tmr_load),
		.value_in(tmr_val),
		.zero_out(tmr_zero)
	);

	// System side: accept a request, wait for its completion
	always_comb begin
		next_busy = busy;
		next_req_tgl = req_tgl;
		next_done_seen = done_seen;
		next_done_pulse = 1'b0;
		next_rdata = rdata;
		next_req_hold = req_hold;
		if (busy && (done_tgl_sync != done_seen)) begin
			// Bus data stays stable until the next request, safe to copy
			next_done_seen = done_tgl_sync;
			next_done_pulse = 1'b1;
			next_rdata = link_rdata;
			next_busy = 1'b0;
		end else if (!busy && req_valid_in) begin
			// Fields are held frozen so the bus side may read them freely
			next_req_hold = req_in;
			next_req_tgl = !req_tgl;
			next_busy = 1'b1;
		end
	end

	// Register system side state
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			busy <= 1'b0;
			req_tgl <= erw_pkg::TGL_RST;
			done_seen <= erw_pkg::TGL_RST;
			done_pulse <= 1'b0;
			rdata <= erw_pkg::DATA_RST;
			req_hold <= '0;
		end else begin
			busy <= next_busy;
			req_tgl <= next_req_tgl;
			done_seen <= next_done_seen;
			done_pulse <= next_done_pulse;
			rdata <= next_rdata;
			req_hold <= next_req_hold;
		end
	end

	// Ready decode with the selected active level
	always_comb begin
		rdy_pin_active = (ready_in == req_hold.ready_pol);
		rdy_async_active = (rdy_sync == req_hold.ready_pol);
		// Different sample points: async sees the pin two periods late
		if (req_hold.ready_async) begin
			rdy_active = rdy_async_active;
		end else begin
			rdy_active = rdy_pin_active;
		end
	end

	// Bus side sequencer: phases, wait states and cycle end
	always_comb begin
		next_state = state;
		next_strobe = strobe;
		next_link_rdata = link_rdata;
		next_dout = dout;
		next_oe_n = oe_n;
		next_req_seen = req_seen;
		next_done_tgl = done_tgl;
		tmr_load = 1'b0;
		tmr_val = '0;
		end_cycle = 1'b0;
		case (state)
			erw_pkg::ERW_IDLE: begin
				if (req_tgl_sync != req_seen) begin
					next_req_seen = req_tgl_sync;
					next_dout = req_hold.wdata;
					next_oe_n = !req_hold.write;
					tmr_load = 1'b1;
					if (req_hold.cmd_delay == 2'h0) begin
						// No command delay: strobe falls at once
						next_state = erw_pkg::ERW_ACCESS;
						next_strobe = strobe_on(req_hold.write);
						tmr_val = len_m1(req_hold.access_len);
					end else begin
						next_state = erw_pkg::ERW_DELAY;
						tmr_val = len_m1({4'h0, req_hold.cmd_delay});
					end
				end
			end
			erw_pkg::ERW_DELAY: begin
				// Strobe falls once the command delay has run out
				if (tmr_zero) begin
					next_state = erw_pkg::ERW_ACCESS;
					next_strobe = strobe_on(req_hold.write);
					tmr_load = 1'b1;
					tmr_val = len_m1(req_hold.access_len);
				end
			end
			erw_pkg::ERW_ACCESS: begin
				// Ready is not looked at before the access phase runs out
				if (tmr_zero) begin
					if (!req_hold.ready_ctrl) begin
						end_cycle = 1'b1;
					end else if (!req_hold.ready_async && rdy_pin_active) begin
						end_cycle = 1'b1;
					end else begin
						// Async always waits at least once for its stage
						next_state = erw_pkg::ERW_RWAIT;
					end
				end
			end
			erw_pkg::ERW_RWAIT: begin
				// Inactive sample keeps us here for one more period
				if (rdy_active) begin
					end_cycle = 1'b1;
				end else begin
					next_state = erw_pkg::ERW_RWAIT;
				end
			end
			erw_pkg::ERW_HOLD: begin
				// Write data stays driven until the hold phase is over
				if (tmr_zero) begin
					next_state = erw_pkg::ERW_IDLE;
					next_oe_n = erw_pkg::OE_N_IDLE;
					next_done_tgl = !done_tgl;
				end
			end
			default: begin
				// Unused state codes fall back to idle
				next_state = erw_pkg::ERW_IDLE;
			end
		endcase
		// Strobe rises and read data is caught on the same edge
		if (end_cycle) begin
			next_strobe = '{rd_n: erw_pkg::STROBE_IDLE, wr_n: erw_pkg::STROBE_IDLE};
			if (!req_hold.write) begin
				next_link_rdata = data_in;
			end
			if (req_hold.hold_len == 2'h0) begin
				next_state = erw_pkg::ERW_IDLE;
				next_oe_n = erw_pkg::OE_N_IDLE;
				next_done_tgl = !done_tgl;
			end else begin
				next_state = erw_pkg::ERW_HOLD;
				tmr_load = 1'b1;
				tmr_val = len_m1({4'h0, req_hold.hold_len});
			end
		end
	end

	// Register bus side state
	always_ff @(posedge clk_link_in) begin
		if (rst_link) begin
			state <= erw_pkg::ERW_IDLE;
			strobe <= '{rd_n: erw_pkg::STROBE_IDLE, wr_n: erw_pkg::STROBE_IDLE};
			link_rdata <= erw_pkg::DATA_RST;
			dout <= erw_pkg::DATA_RST;
			oe_n <= erw_pkg::OE_N_IDLE;
			req_seen <= erw_pkg::TGL_RST;
			done_tgl <= erw_pkg::TGL_RST;
		end else begin
			state <= next_state;
			strobe <= next_strobe;
			link_rdata <= next_link_rdata;
			dout <= next_dout;
			oe_n <= next_oe_n;
			req_seen <= next_req_seen;
			done_tgl <= next_done_tgl;
		end
	end

	// Outputs; the bus clock is forwarded as the reference clock
	assign req_ready_out = !busy;
	assign done_out = done_pulse;
	assign rdata_out = rdata;
	assign data_out = dout;
	assign data_oe_n_out = oe_n;
	assign strobe_out = strobe;
	assign bus_reference_clock_out = clk_link_in;
endmodule

// ---- tb/erw_ready_ctrl_assertions.sv ----
// Port checker for the ready and wait-state sequencer
`timescale 1ns/1ps
module erw_ready_ctrl_assertions (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic clk_link_in,
	input wire logic req_valid_in,
	input wire erw_pkg::erw_req_t req_in,
	input wire logic req_ready_out,
	input wire logic done_out,
	input wire logic [erw_pkg::DATA_W-1:0] rdata_out,
	input wire logic ready_in,
	input wire erw_pkg::erw_strobe_t strobe_out
);
	erw_pkg::erw_req_t cfg; // Settings of the running cycle
	erw_pkg::erw_req_t next_cfg;
	int low_len; // Link edges seen with a strobe low
	int next_low_len;
	// Settings only move on acceptance, so the link side may read them
	always_comb next_cfg = (req_valid_in && req_ready_out) ? req_in : cfg;
	always_ff @(posedge clk_sys_in) cfg <= next_cfg;
	always_comb next_low_len = (&strobe_out) ? 0 : low_len + 1;
	always_ff @(posedge clk_link_in) low_len <= next_low_len;
	sequence s_end;
		$rose(&strobe_out) && cfg.ready_ctrl;
	endsequence
	// Free again in the done cycle itself, and done lasts one cycle
	sequence s_release;
		req_ready_out ##1 !done_out;
	endsequence
	a_plain_length: assert property (@(posedge clk_link_in) disable iff (rst_in)
		$rose(&strobe_out) && !cfg.ready_ctrl |-> low_len == int'(cfg.access_len))
		else $error("plain cycle length wrong");
	a_ready_minimum: assert property (@(posedge clk_link_in) disable iff (rst_in)
		s_end |-> low_len >= int'(cfg.access_len)) else $error("access phase cut short");
	a_async_extra: assert property (@(posedge clk_link_in) disable iff (rst_in)
		s_end ##0 cfg.ready_async |-> low_len > int'(cfg.access_len))
		else $error("async cycle without wait");
	a_sync_end: assert property (@(posedge clk_link_in) disable iff (rst_in)
		s_end ##0 !cfg.ready_async |-> $past(ready_in) == cfg.ready_pol)
		else $error("sync cycle ended without ready");
	a_async_end: assert property (@(posedge clk_link_in) disable iff (rst_in)
		s_end ##0 cfg.ready_async |-> $past(ready_in, 3) == cfg.ready_pol)
		else $error("async cycle ended without ready");
	a_wait_inactive: assert property (@(posedge clk_link_in) disable iff (rst_in)
		!(&strobe_out) && cfg.ready_ctrl && !cfg.ready_async && ready_in != cfg.ready_pol
		|=> !(&strobe_out)) else $error("cycle ended on inactive ready");
	a_done_release: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		done_out |-> s_release) else $error("ready to accept at wrong time");
	a_rdata_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		$changed(rdata_out) |-> done_out) else $error("read data moved without done");
endmodule
bind erw_ready_ctrl erw_ready_ctrl_assertions erw_ready_ctrl_assertions_inst (
	.clk_sys_in(clk_sys_in), .rst_in(rst_in), .clk_link_in(clk_link_in),
	.req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
	.done_out(done_out), .rdata_out(rdata_out), .ready_in(ready_in), .strobe_out(strobe_out));

// ---- tb/erw_bus_partner.sv ----
// Model of the external part that drives ready and read data
`timescale 1ns/1ps
module erw_bus_partner (
	input wire logic clk_in,
	input wire erw_pkg::erw_strobe_t strobe_in,
	input wire logic pol_in,
	input wire logic [5:0] delay_in,
	input wire logic [15:0] value_in,
	output logic ready_out,
	output logic [15:0] data_out
);
	int periods = 0; // Edges seen with a strobe low
	// Ready moves just after a bus clock edge
	always @(posedge clk_in) begin
		if (&strobe_in) begin
			periods <= 0;
			ready_out <= !pol_in;
		end else begin
			periods <= periods + 1;
			// Held active until the strobe rises, well over one period
			ready_out <= (periods + 1 >= delay_in) ? pol_in : !pol_in;
		end
	end
	// Released data shows the inverse, so a late latch reads wrong
	assign data_out = strobe_in.rd_n ? ~value_in : value_in;
endmodule

// ---- tb/erw_ready_ctrl_tb.sv ----
// Self-checking bench for the ready and wait-state sequencer
`timescale 1ns/1ps
module erw_ready_ctrl_tb;
	logic clk_sys_in = 1'b0;
	logic clk_link_in = 1'b0;
	logic rst_in = 1'b1;
	logic req_valid_in = 1'b0;
	erw_pkg::erw_req_t req_in = '0;
	logic req_ready_out, done_out, oe_n, ref_clk, ready_in;
	logic [15:0] rdata_out, data_in, data_out;
	erw_pkg::erw_strobe_t strobe_out;
	logic pol = 1'b1; // Partner settings
	logic [5:0] delay = 6'h00;
	logic [15:0] value = 16'h0000;
	logic [31:0] lfsr = 32'h9a5fe606;
	int fail_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	int run_len = 0; // Bus monitor state
	int meas_len = 0;
	logic meas_wr = 1'b0;
	logic last_wr = 1'b0;
	logic [15:0] meas_data = 16'h0000;
	logic [15:0] last_data = 16'h0000;
	int oe_total = 0; // Link edges seen with data driven
	int oe_base = 0;
	always #50 clk_sys_in = ~clk_sys_in;
	// Link clock runs free, offset in phase
	initial begin
		#17;
		forever #62.5 clk_link_in = ~clk_link_in;
	end
	erw_ready_ctrl erw_ready_ctrl_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.clk_link_in(clk_link_in), .req_valid_in(req_valid_in), .req_in(req_in),
		.req_ready_out(req_ready_out), .done_out(done_out), .rdata_out(rdata_out),
		.ready_in(ready_in), .data_in(data_in), .data_out(data_out), .data_oe_n_out(oe_n),
		.strobe_out(strobe_out), .bus_reference_clock_out(ref_clk));
	erw_bus_partner erw_bus_partner_inst (.clk_in(ref_clk), .strobe_in(strobe_out),
		.pol_in(pol), .delay_in(delay), .value_in(value), .ready_out(ready_in), .data_out(data_in));
	// Strobe-low length, driven-data time and bus data of each cycle
	always @(posedge clk_link_in) begin
		if (!oe_n) oe_total <= oe_total + 1;
		if (&strobe_out) begin
			if (run_len != 0) begin
				meas_len <= run_len;
				meas_wr <= last_wr;
				meas_data <= last_data;
			end
			run_len <= 0;
		end else begin
			run_len <= run_len + 1;
			last_wr <= !strobe_out.wr_n;
			last_data <= data_out;
		end
	end
	// Hang guard, far above the expected run
	always @(posedge clk_sys_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	function automatic logic [31:0] lfsr_next(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Expected strobe-low periods; partner ready is seen from edge max(2, d+1)
	function automatic int exp_len(erw_pkg::erw_req_t r, int d);
		int a = int'(r.access_len);
		int s = (d + 1 > 2) ? d + 1 : 2;
		if (!r.ready_ctrl) return a;
		if (!r.ready_async) return (a > s) ? a : s;
		return (a + 1 > s + 2) ? a + 1 : s + 2;
	endfunction
	task automatic chk_data(string name, logic [15:0] exp, logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk_len(string name, int exp, int got);
		samples_checked++;
		if (got != exp) begin
			fail_count++;
			$display("MISMATCH %s expected %0d seen %0d", name, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		erw_pkg::erw_req_t r;
		int n;
		int d;
		repeat (10) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		repeat (5) @(posedge clk_sys_in);
		// Every mode and polarity, random phases, access boundaries first
		for (int i = 0; i < 40; i++) begin
			lfsr = lfsr_next(lfsr);
			r = lfsr[29:0];
			{r.write, r.ready_pol, r.ready_async, r.ready_ctrl} = 4'(i);
			r.access_len = (i == 0) ? 6'h01 : (i == 1) ? 6'h20 : {1'b0, r.access_len[4:0]} + 6'h01;
			d = int'(lfsr[31:29]);
			@(posedge clk_sys_in);
			oe_base = oe_total;
			req_in <= r;
			req_valid_in <= 1'b1;
			pol <= r.ready_pol;
			delay <= {3'h0, lfsr[31:29]};
			value <= lfsr[31:16];
			@(posedge clk_sys_in);
			req_in <= ~r; // Ignored while busy
			repeat (2) @(posedge clk_sys_in);
			req_valid_in <= 1'b0;
			n = 0;
			do begin
				@(posedge clk_sys_in);
				#1;
				n++;
			end while (done_out !== 1'b1 && n < 600);
			chk_len("done", 1, int'(n < 600));
			if (!r.write) chk_data("rdata", lfsr[31:16], rdata_out);
			repeat (2) @(posedge clk_sys_in);
			chk_len("length", exp_len(r, d), meas_len);
			chk_len("kind", int'(r.write), int'(meas_wr));
			// Data is driven through delay, strobe and hold phases of writes only
			n = r.write ? int'(r.cmd_delay) + exp_len(r, d) + int'(r.hold_len) : 0;
			chk_len("oe_low", n, oe_total - oe_base);
			if (r.write) chk_data("wdata", r.wdata, meas_data);
			$display("test %0d done", i);
		end
		tally_and_finish();
	end
endmodule
